// ==== hw/elic_pkg.sv ====
/*
  Package for the enhanced link integrity check block: constants, states, carriers.
  Assumes one 40 MHz clock and frame sync pulses synchronous to it.
*/
// How it works
// [R1] Load enhanced check every 16 syncs
// [R2] Receiver refreshes its value on same schedule
// [R3] Keep encrypting during the enhanced check
// [R4] Host compares both values every 16 frames
// [R5] Host fails after three mismatches
// [R6] Host masks inputs after failure
// [R7] Host clears encryption enable on both ends
// [R8] Enable cleared: pass content unencrypted
// [R9] Receiver outputs plain data when disabled
// [R10] Host writes cipher reset then start
// [R11] Power-up idle until authentication starts
// [R12] Repeater controller sets repeater bit, retries
// [R13] Repeater bit written before first phase
// [R14] Regular check updated every 128 syncs
// [R15] Check registers update atomically at frame boundary
package elic_pkg;
  localparam int ELIC_DATA_W = 24;
  localparam int ELIC_ENH_W = 8;
  localparam int ELIC_REG_W = 16;
  localparam logic [7:0] ELIC_ENH_PERIOD = 8'h10;
  localparam logic [7:0] ELIC_REG_PERIOD = 8'h80;
  localparam logic [7:0] ELIC_CNT_RST = 8'h00;

  typedef enum logic [2:0] {
    ELIC_IDLE = 3'b001,
    ELIC_AUTH = 3'b010,
    ELIC_ENC = 3'b100
  } elic_state_t;

  typedef struct packed {
    logic [ELIC_DATA_W-1:0] data;
    logic valid;
  } elic_av_t;

  typedef struct packed {
    logic [ELIC_ENH_W-1:0] enh;
    logic [ELIC_REG_W-1:0] reg_chk;
  } elic_chk_t;

  typedef struct packed {
    elic_state_t state;
    logic [7:0] frame_cnt;
    logic [ELIC_REG_W-1:0] acc;
    elic_chk_t chk;
    elic_av_t out;
  } elic_st_t;
endpackage : elic_pkg

// ==== hw/elic_core.sv ====
/*
  Serializer-side check value generator and content encryptor.
  Assumes keystream comes from the cipher outside; frame_sync is a one-cycle pulse.
*/
`timescale 1ns/10ps
module elic_core
  import elic_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic cipher_reset,
  input wire logic auth_start,
  input wire logic auth_done,
  input wire logic encryption_enable,
  input wire logic frame_sync,
  input wire elic_av_t av_in,
  input wire logic [ELIC_DATA_W-1:0] keystream,
  output elic_av_t av_out,
  output logic [ELIC_ENH_W-1:0] enhanced_check_value,
  output logic [ELIC_REG_W-1:0] regular_check_value,
  output logic encrypting,
  output logic idle
);
  elic_st_t st;
  elic_st_t next_st;
  logic enc_on;

  assign enc_on = (st.state == ELIC_ENC) && encryption_enable;

  always_comb begin
    next_st = st;
    case (st.state)
      ELIC_IDLE: begin
        if (auth_start) begin // [R11]
          next_st.state = ELIC_AUTH;
        end
      end
      ELIC_AUTH: begin
        if (cipher_reset) begin
          next_st.state = ELIC_IDLE;
        end else if (auth_done && encryption_enable) begin
          next_st.state = ELIC_ENC;
          next_st.frame_cnt = ELIC_CNT_RST;
          next_st.acc = '0;
        end
      end
      ELIC_ENC: begin
        if (cipher_reset) begin
          next_st.state = ELIC_IDLE;
        end else if (!encryption_enable) begin // [R8]
          next_st.state = ELIC_AUTH;
        end
      end
      default: next_st.state = ELIC_IDLE;
    endcase
    // Running digest of the key stream, folded each valid pixel while encrypting
    if (enc_on && av_in.valid) begin
      next_st.acc = {st.acc[ELIC_REG_W-2:0], st.acc[ELIC_REG_W-1]}
        ^ keystream[ELIC_REG_W-1:0];
    end
    // Loads only on the sync edge, so a read never sees half a value
    if (enc_on && frame_sync) begin
      next_st.frame_cnt = (st.frame_cnt == ELIC_REG_PERIOD - 8'h01) ? ELIC_CNT_RST
        : st.frame_cnt + 8'h01;
      if (st.frame_cnt[3:0] == 4'hF) begin // [R1] [R15]
        next_st.chk.enh = st.acc[ELIC_ENH_W-1:0] ^ st.acc[ELIC_REG_W-1:ELIC_ENH_W];
      end
      if (st.frame_cnt == ELIC_REG_PERIOD - 8'h01) begin // [R14] [R15]
        next_st.chk.reg_chk = st.acc;
      end
    end
    // Content keeps flowing in every state; only the mask changes
    next_st.out.valid = av_in.valid; // [R3]
    next_st.out.data = enc_on ? (av_in.data ^ keystream) : av_in.data; // [R3] [R8]
    if (cipher_reset) begin
      next_st.chk = '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st <= '{state: ELIC_IDLE, frame_cnt: ELIC_CNT_RST, acc: '0, chk: '0, out: '0};
    end else begin
      st <= next_st;
    end
  end

  assign av_out = st.out;
  assign enhanced_check_value = st.chk.enh;
  assign regular_check_value = st.chk.reg_chk;
  assign encrypting = enc_on;
  assign idle = (st.state == ELIC_IDLE);

  AST_ENH_ONLY_AT_16: assert property (@(posedge ref_clk) disable iff (rst) // [R1]
    (st.chk.enh != $past(st.chk.enh)) && !$past(cipher_reset)
      |-> $past(frame_sync) && ($past(st.frame_cnt[3:0]) == 4'hF))
    else $error("Enhanced check changed off schedule");
  AST_REG_ONLY_AT_128: assert property (@(posedge ref_clk) disable iff (rst) // [R14]
    (st.chk.reg_chk != $past(st.chk.reg_chk)) && !$past(cipher_reset)
      |-> $past(frame_sync) && ($past(st.frame_cnt) == 8'h7F))
    else $error("Regular check changed off schedule");
  AST_STABLE_NO_SYNC: assert property (@(posedge ref_clk) disable iff (rst) // [R15]
    !frame_sync && !cipher_reset |=> $stable(st.chk))
    else $error("Check value changed without frame boundary");
  AST_ENC_XOR: assert property (@(posedge ref_clk) disable iff (rst) // [R3]
    enc_on |=> av_out.data == ($past(av_in.data) ^ $past(keystream)))
    else $error("Encrypted output wrong");
  AST_PLAIN_WHEN_OFF: assert property (@(posedge ref_clk) disable iff (rst) // [R8]
    !encryption_enable |=> av_out.data == $past(av_in.data))
    else $error("Content not passed plain when disabled");
  AST_VALID_FLOWS: assert property (@(posedge ref_clk) disable iff (rst) // [R3]
    1'b1 |=> av_out.valid == $past(av_in.valid))
    else $error("Content flow interrupted");

  // Frame counter: restarts with encryption, steps only on syncs while encrypting
  AST_CNT_CLEAR_AT_START: assert property (@(posedge ref_clk) disable iff (rst) // [R1]
    (st.state == ELIC_AUTH) && !cipher_reset && auth_done && encryption_enable
      |=> (st.frame_cnt == ELIC_CNT_RST) && (st.acc == '0))
    else $error("Frame count not restarted at encryption start");

  AST_SYNC_IGNORED_OFF: assert property (@(posedge ref_clk) disable iff (rst) // [R1]
    !enc_on && !auth_done |=> $stable(st.frame_cnt))
    else $error("Frame count moved while not encrypting");

  AST_CNT_STEP: assert property (@(posedge ref_clk) disable iff (rst) // [R1]
    enc_on && frame_sync && (st.frame_cnt != 8'h7F)
      |=> st.frame_cnt == ($past(st.frame_cnt) + 8'h01))
    else $error("Frame count did not step on sync");

  AST_CNT_WRAP: assert property (@(posedge ref_clk) disable iff (rst) // [R14]
    enc_on && frame_sync && (st.frame_cnt == 8'h7F) |=> st.frame_cnt == ELIC_CNT_RST)
    else $error("Frame count did not wrap after the long period");

  // Digest moves only on valid pixels while encrypting and clears at encryption start; gaps must not disturb it
  AST_ACC_HOLD: assert property (@(posedge ref_clk) disable iff (rst) // [R1]
    !(enc_on && av_in.valid) && !auth_done |=> $stable(st.acc))
    else $error("Digest moved without a valid pixel");

  AST_ACC_FOLD: assert property (@(posedge ref_clk) disable iff (rst) // [R1]
    enc_on && av_in.valid && !(frame_sync && 1'b0)
      |=> st.acc == ({$past(st.acc[ELIC_REG_W-2:0]), $past(st.acc[ELIC_REG_W-1])}
        ^ $past(keystream[ELIC_REG_W-1:0])))
    else $error("Digest fold wrong");

  // Loaded values come from the digest as it stood at the sync
  AST_ENH_LOAD_VALUE: assert property (@(posedge ref_clk) disable iff (rst) // [R1]
    enc_on && frame_sync && (st.frame_cnt[3:0] == 4'hF) && !cipher_reset
      |=> st.chk.enh == ($past(st.acc[ELIC_ENH_W-1:0]) ^ $past(st.acc[ELIC_REG_W-1:ELIC_ENH_W])))
    else $error("Enhanced check loaded with wrong value");

  AST_REG_LOAD_VALUE: assert property (@(posedge ref_clk) disable iff (rst) // [R14]
    enc_on && frame_sync && (st.frame_cnt == 8'h7F) && !cipher_reset
      |=> st.chk.reg_chk == $past(st.acc))
    else $error("Regular check loaded with wrong value");

  AST_CHK_HELD_OFF: assert property (@(posedge ref_clk) disable iff (rst) // [R15]
    !enc_on && !cipher_reset |=> $stable(st.chk))
    else $error("Check value changed while not encrypting");

  // Cipher reset always clears check values; it lands in idle unless it meets auth_start while idle
  AST_RESET_CLEARS: assert property (@(posedge ref_clk) disable iff (rst) // [R11]
    cipher_reset |=> (st.chk == '0) && (st.state == ELIC_IDLE))
    else $error("Cipher reset did not clear");

  AST_STATE_ONEHOT: assert property (@(posedge ref_clk) disable iff (rst) // [R11]
    $onehot(st.state))
    else $error("State code not one-hot");

  AST_ENC_ENTRY: assert property (@(posedge ref_clk) disable iff (rst) // [R11]
    (st.state == ELIC_ENC) && ($past(st.state) != ELIC_ENC)
      |-> $past(auth_done) && $past(encryption_enable) && ($past(st.state) == ELIC_AUTH))
    else $error("Encryption entered without authentication");

  AST_AUTH_HOLDS: assert property (@(posedge ref_clk) disable iff (rst) // [R11]
    (st.state == ELIC_AUTH) && !cipher_reset && !(auth_done && encryption_enable)
      |=> st.state == ELIC_AUTH)
    else $error("Left authenticating without cause");

  AST_ENC_HOLDS: assert property (@(posedge ref_clk) disable iff (rst) // [R3]
    (st.state == ELIC_ENC) && encryption_enable && !cipher_reset |=> st.state == ELIC_ENC)
    else $error("Encryption dropped while enabled");

  AST_DISABLE_LEAVES_ENC: assert property (@(posedge ref_clk) disable iff (rst) // [R8]
    (st.state == ELIC_ENC) && !encryption_enable && !cipher_reset |=> st.state == ELIC_AUTH)
    else $error("Encryption kept after enable cleared");

  // Outside encryption the content must pass untouched
  AST_PLAIN_OUTSIDE_ENC: assert property (@(posedge ref_clk) disable iff (rst) // [R8]
    (st.state != ELIC_ENC) |=> av_out.data == $past(av_in.data))
    else $error("Content masked outside encryption");
  AST_IDLE_UNTIL_START: assert property (@(posedge ref_clk) disable iff (rst) // [R11]
    idle && !auth_start |=> idle)
    else $error("Left idle without start");
  AST_NO_ENC_IN_IDLE: assert property (@(posedge ref_clk) disable iff (rst) // [R11]
    idle |-> !encrypting)
    else $error("Encrypting before authentication");

  COV_ENH_UPDATE: cover property (@(posedge ref_clk) disable iff (rst)
    enc_on && frame_sync && st.frame_cnt[3:0] == 4'hF);
  COV_REG_UPDATE: cover property (@(posedge ref_clk) disable iff (rst)
    enc_on && frame_sync && st.frame_cnt == 8'h7F);
  COV_DISABLE: cover property (@(posedge ref_clk) disable iff (rst)
    enc_on ##1 !encryption_enable);
  COV_RESTART: cover property (@(posedge ref_clk) disable iff (rst)
    cipher_reset ##[1:20] auth_start);
  COV_ENC_START: cover property (@(posedge ref_clk) disable iff (rst)
    (st.state == ELIC_AUTH) ##1 (st.state == ELIC_ENC));
endmodule : elic_core

// ==== test/elic_rx_model.sv ====
/* Receiver model: strips the keystream and builds its own check value.
   Assumes the bench hands it the keystream one cycle late. */
`timescale 1ns/10ps
module elic_rx_model
  import elic_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic dec_en,
  input wire logic frame_sync,
  input wire elic_av_t link_in,
  input wire logic [23:0] key,
  output logic [23:0] plain,
  output logic [7:0] rx_check,
  output logic [15:0] rx_regular
);
  logic [15:0] acc;
  logic [6:0] cnt;
  assign plain = dec_en ? link_in.data ^ key : link_in.data;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      acc <= 16'h0000;
      cnt <= 7'h00;
      rx_check <= 8'h00;
      rx_regular <= 16'h0000;
    end else if (dec_en) begin
      if (link_in.valid) acc <= {acc[14:0], acc[15]} ^ key[15:0];
      if (frame_sync) begin
        cnt <= cnt + 7'h01;
        if (cnt[3:0] == 4'hF) rx_check <= acc[7:0] ^ acc[15:8];
        if (cnt == 7'h7F) rx_regular <= acc;
      end
    end
  end
endmodule : elic_rx_model

// ==== test/enhanced_link_integrity_check_tb.sv ====
/* Bench for the check generator: frames of pixels, enable and reset sequences.
   Assumes the receiver model beside it for expected check values. */
`timescale 1ns/10ps
module enhanced_link_integrity_check_tb
  import elic_pkg::*;
;
  logic ref_clk = 0, rst = 1, cipher_reset = 0, auth_start = 0, auth_done = 0;
  logic enc_en = 0, frame_sync = 0, rx_en = 0, encrypting, idle;
  elic_av_t av_in = '0, av_out;
  logic [23:0] key = 24'h000000, key_d = 24'h000000, plain;
  logic [7:0] enh, rx_chk;
  logic [15:0] reg_chk, rx_reg;
  int num_errors = 0, samples_checked = 0, cycles = 0;
  elic_core elic_core_i (.ref_clk(ref_clk), .rst(rst), .cipher_reset(cipher_reset),
    .auth_start(auth_start), .auth_done(auth_done), .encryption_enable(enc_en),
    .frame_sync(frame_sync), .av_in(av_in), .keystream(key), .av_out(av_out),
    .enhanced_check_value(enh), .regular_check_value(reg_chk),
    .encrypting(encrypting), .idle(idle));
  elic_rx_model elic_rx_model_i (.ref_clk(ref_clk), .rst(rst), .dec_en(rx_en),
    .frame_sync(frame_sync), .link_in(av_out), .key(key_d), .plain(plain), .rx_check(rx_chk),
    .rx_regular(rx_reg));
  initial forever #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) key_d <= key;
  task automatic print_verdict();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      print_verdict();
    end
  end
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  task automatic tick(input int n = 1);
    repeat (n) @(negedge ref_clk);
  endtask : tick
  // Idle gap before the sync so the model's late pixel lands first
  task automatic frame(input int n, input logic enc);
    logic [23:0] d;
    for (int i = 0; i < n; i++) begin
      d = 24'(i * 24'h013579 + cycles);
      av_in = '{data: d, valid: 1'b1};
      key = 24'(i * 24'h2468AC + 24'h5A1111);
      tick();
      chk("av_out", enc ? d ^ key : d, av_out.data);
      chk("rx plain", d, plain);
    end
    av_in.valid = 1'b0;
    tick();
    frame_sync = 1;
    tick();
    frame_sync = 0;
  endtask : frame
  initial begin
    tick(20);
    rst = 0;
    // Repeater setup lives outside this block; start follows the cipher reset with no wait on it
    chk("idle", 24'h000001, idle);
    chk("encrypting", 24'h000000, encrypting);
    cipher_reset = 1;
    tick();
    cipher_reset = 0;
    auth_start = 1;
    tick();
    auth_start = 0;
    enc_en = 1;
    auth_done = 1;
    tick();
    auth_done = 0;
    rx_en = 1;
    chk("encrypting", 24'h000001, encrypting);
    repeat (15) frame(4, 1);
    chk("enh early", 24'h000000, enh);
    frame(4, 1);
    chk("enh", rx_chk, enh);
    chk("regular", 24'h000000, reg_chk);
    for (int k = 1; k < 8; k++) begin
      repeat (16) frame(4, 1);
      chk("enh", 24'(rx_chk), 24'(enh));
    end
    chk("regular", 24'(rx_reg), 24'(reg_chk));
    enc_en = 0;
    rx_en = 0;
    frame(3, 0);
    chk("enh held", rx_chk, enh);
    cipher_reset = 1;
    tick();
    cipher_reset = 0;
    tick();
    chk("enh cleared", 24'h000000, enh);
    chk("idle", 24'h000001, idle);
    print_verdict();
  end
endmodule : enhanced_link_integrity_check_tb
